// file: src/cmd_port_pkg.sv
// constants, state layout and reset values of the serial command port
// assumes a single 100 MHz clock and an asynchronous active high reset
// Overview of operation
// - up to two data bytes are kept after each command address, each sent msb first and assembled in order.
// - reply bytes leave on the reply line msb first, lsb last.
// - every command bit is taken on a rising edge of the serial clock.
// - a command is carried out only when the select line rises, never mid-transfer.
// - the serial clock may idle either low or high between transfers.
package cmd_port_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam real SEL_GAP_US = 1.0;
  localparam int SEL_GAP_CYC = int'(SEL_GAP_US * 1000.0) / CLK_PERIOD_NS;
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam logic [1:0] MAX_DATA_BYTES = 2'h2;
  localparam logic SEL_IDLE = 1'b1;
  localparam logic SCLK_RST = 1'b0;

  typedef struct packed {
    logic sel_prev;
    logic sclk_prev;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic addr_done;
    logic [1:0] nbytes;
    logic [7:0] addr;
    logic [15:0] data;
    logic [7:0] tx_sh;
    logic rdata;
    logic oe;
    logic cmd_valid;
    logic addr_valid;
    logic reply_load;
  } port_state_s;

  localparam port_state_s PORT_RST = '{
    sel_prev: SEL_IDLE, sclk_prev: SCLK_RST, bit_cnt: 3'h0, shreg: 8'h00,
    addr_done: 1'b0, nbytes: 2'h0, addr: 8'h00, data: 16'h0000, tx_sh: 8'h00,
    rdata: 1'b0, oe: 1'b0, cmd_valid: 1'b0, addr_valid: 1'b0, reply_load: 1'b0};

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic lvl;
  } sync_state_s;
endpackage

// file: src/pin_if.sv
// one pin on its way from the outside world to its filtered level
// assumes the raw side is asynchronous to clk
`timescale 1ns/1ps
interface pin_if;
  logic raw;
  logic lvl;
  modport sync (input raw, output lvl);
  modport user (output raw, input lvl);
endinterface

// file: src/pin_sync.sv
// three-stage synchroniser with agreement filter for one pin
// assumes the pin toggles slower than a few clk periods
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RST_LVL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  pin_if.sync pin
);
  import cmd_port_pkg::*;

  sync_state_s st_r;
  sync_state_s st_nxt;

  // ff1 feeds ff2 only; a new level counts once ff2 and ff3 agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.ff1 = pin.raw;
    st_nxt.ff2 = st_r.ff1;
    st_nxt.ff3 = st_r.ff2;
    if (st_r.ff2 == st_r.ff3) begin
      st_nxt.lvl = st_r.ff3;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{ff1: RST_LVL, ff2: RST_LVL, ff3: RST_LVL, lvl: RST_LVL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin.lvl = st_r.lvl;
endmodule

// file: src/host_serial_command_port.sv
// serial command port: select, serial clock, command data in, reply data out
// assumes the host clock is far slower than clk (high and low of at least 100 ns)
`timescale 1ns/1ps
module host_serial_command_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic select_n,
  input wire logic serial_clk,
  input wire logic command_data_in,
  output logic reply_data_out,
  output logic reply_data_oe,
  input wire logic reply_en,
  input wire logic [7:0] reply_data,
  output logic reply_load,
  output logic addr_valid,
  output logic cmd_valid,
  output logic [7:0] cmd_addr,
  output logic [15:0] cmd_data,
  output logic [1:0] cmd_len
);
  import cmd_port_pkg::*;

  pin_if sel_pin ();
  pin_if clk_pin ();
  pin_if din_pin ();

  assign sel_pin.raw = select_n;
  assign clk_pin.raw = serial_clk;
  assign din_pin.raw = command_data_in;

  ////////////////////////////////////////////////////////////////////////////
  // pin conditioning

  pin_sync #(.RST_LVL(SEL_IDLE)) u_sel_sync (.clk(clk), .rst(rst), .pin(sel_pin));
  pin_sync #(.RST_LVL(SCLK_RST)) u_clk_sync (.clk(clk), .rst(rst), .pin(clk_pin));
  pin_sync #(.RST_LVL(1'b0)) u_din_sync (.clk(clk), .rst(rst), .pin(din_pin));

  ////////////////////////////////////////////////////////////////////////////
  // transfer engine

  port_state_s st_r;
  port_state_s st_nxt;
  logic selected;
  logic sel_fall;
  logic sel_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] full_byte;

  // edges are taken from filtered levels; the clock idle level only decides whether a closing fall loads a reply byte
  assign selected = ~sel_pin.lvl;
  assign sel_fall = st_r.sel_prev & ~sel_pin.lvl;
  assign sel_rise = ~st_r.sel_prev & sel_pin.lvl;
  assign sclk_rise = ~st_r.sclk_prev & clk_pin.lvl;
  assign sclk_fall = st_r.sclk_prev & ~clk_pin.lvl;
  assign full_byte = {st_r.shreg[6:0], din_pin.lvl};

  always_comb begin
    st_nxt = st_r;
    st_nxt.sel_prev = sel_pin.lvl;
    st_nxt.sclk_prev = clk_pin.lvl;
    st_nxt.cmd_valid = 1'b0;
    st_nxt.addr_valid = 1'b0;
    st_nxt.reply_load = 1'b0;
    if (!selected) begin
      // clock edges while deselected are ignored, whichever level it idles at
      st_nxt.bit_cnt = FIRST_BIT;
      st_nxt.oe = 1'b0;
      // a partial trailing byte is dropped; only whole bytes count
      if (sel_rise && st_r.addr_done) begin
        st_nxt.cmd_valid = 1'b1;
      end
    end else if (sel_fall) begin
      // new transfer: address expected first
      st_nxt.bit_cnt = FIRST_BIT;
      st_nxt.addr_done = 1'b0;
      st_nxt.nbytes = 2'h0;
      st_nxt.data = 16'h0000;
      st_nxt.oe = 1'b0;
    end else begin
      if (sclk_rise) begin
        // msb arrives first, so shift left and enter at bit 0
        st_nxt.shreg = full_byte;
        st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
        if (st_r.bit_cnt == LAST_BIT) begin
          if (!st_r.addr_done) begin
            st_nxt.addr = full_byte;
            st_nxt.addr_done = 1'b1;
            st_nxt.addr_valid = 1'b1;
          end else if (st_r.nbytes != MAX_DATA_BYTES) begin
            // first data byte ends up in the upper half when two are sent
            st_nxt.data = {st_r.data[7:0], full_byte};
            st_nxt.nbytes = st_r.nbytes + 2'h1;
          end
        end
      end
      if (sclk_fall && st_r.addr_done) begin
        // drive on the falling edge so the host sees it stable at its rising edge
        if (st_r.bit_cnt == FIRST_BIT) begin
          st_nxt.rdata = reply_data[7];
          st_nxt.tx_sh = {reply_data[6:0], 1'b0};
          st_nxt.reply_load = 1'b1;
          st_nxt.oe = reply_en;
        end else begin
          st_nxt.rdata = st_r.tx_sh[7];
          st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= PORT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from the state register

  assign reply_data_out = st_r.rdata;
  assign reply_data_oe = st_r.oe;
  assign reply_load = st_r.reply_load;
  assign addr_valid = st_r.addr_valid;
  assign cmd_valid = st_r.cmd_valid;
  assign cmd_addr = st_r.addr;
  assign cmd_data = st_r.data;
  assign cmd_len = st_r.nbytes;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // each property restates one line of the contract on registered state

  property p_exec_at_select_rise;
    @(posedge clk) disable iff (rst)
      cmd_valid |-> $past(sel_rise) && $past(st_r.addr_done) && !selected;
  endproperty
  a_exec_at_select_rise: assert property (p_exec_at_select_rise)
    else $error("command executed without a select rise");

  property p_exec_follows_rise;
    @(posedge clk) disable iff (rst)
      (sel_rise && st_r.addr_done) |=> cmd_valid ##1 !cmd_valid;
  endproperty
  a_exec_follows_rise: assert property (p_exec_follows_rise)
    else $error("select rise did not give exactly one execute pulse");

  property p_sample_on_rise;
    @(posedge clk) disable iff (rst)
      (selected && !sel_fall && sclk_rise) |=>
        st_r.shreg[0] == $past(din_pin.lvl) && st_r.bit_cnt == $past(st_r.bit_cnt) + 3'h1;
  endproperty
  a_sample_on_rise: assert property (p_sample_on_rise)
    else $error("command bit not taken on serial clock rise");

  property p_address_first;
    @(posedge clk) disable iff (rst)
      (selected && !sel_fall && sclk_rise && st_r.bit_cnt == LAST_BIT && !st_r.addr_done)
        |=> addr_valid && st_r.addr_done && cmd_addr == $past(full_byte) && cmd_len == 2'h0;
  endproperty
  a_address_first: assert property (p_address_first)
    else $error("first byte not taken as command address");

  property p_data_order;
    @(posedge clk) disable iff (rst)
      (selected && !sel_fall && sclk_rise && st_r.bit_cnt == LAST_BIT && st_r.addr_done
        && st_r.nbytes == 2'h1) |=> cmd_data == {$past(st_r.data[7:0]), $past(full_byte)};
  endproperty
  a_data_order: assert property (p_data_order)
    else $error("data bytes not assembled first byte high");

  property p_reply_msb_first;
    @(posedge clk) disable iff (rst)
      (selected && !sel_fall && sclk_fall && st_r.addr_done && st_r.bit_cnt == FIRST_BIT)
        |=> reply_data_out == $past(reply_data[7]) && reply_load;
  endproperty
  a_reply_msb_first: assert property (p_reply_msb_first)
    else $error("reply byte did not start with its msb");

  property p_idle_clock_ignored;
    @(posedge clk) disable iff (rst)
      (!selected && !sel_fall) |=> st_r.bit_cnt == FIRST_BIT && !reply_data_oe;
  endproperty
  a_idle_clock_ignored: assert property (p_idle_clock_ignored)
    else $error("serial clock counted while deselected");

  // bytes past the second leave the assembled data alone
  property p_extra_bytes_ignored;
    @(posedge clk) disable iff (rst)
      (selected && !sel_fall && sclk_rise && st_r.bit_cnt == LAST_BIT && st_r.addr_done
        && st_r.nbytes == MAX_DATA_BYTES) |=> $stable(cmd_data) && cmd_len == MAX_DATA_BYTES;
  endproperty
  a_extra_bytes_ignored: assert property (p_extra_bytes_ignored)
    else $error("data byte past the second changed the command data");

  // later reply bits come from the shift register, one per falling edge
  property p_reply_shift;
    @(posedge clk) disable iff (rst)
      (selected && !sel_fall && sclk_fall && st_r.addr_done && st_r.bit_cnt != FIRST_BIT)
        |=> reply_data_out == $past(st_r.tx_sh[7]);
  endproperty
  a_reply_shift: assert property (p_reply_shift)
    else $error("reply bit not taken from the shift register");

  // a reply byte is only ever taken at the first falling edge of a byte
  property p_load_at_byte_start;
    @(posedge clk) disable iff (rst)
      reply_load |-> $past(sclk_fall) && $past(st_r.addr_done)
        && $past(st_r.bit_cnt) == FIRST_BIT;
  endproperty
  a_load_at_byte_start: assert property (p_load_at_byte_start)
    else $error("reply byte loaded away from a byte start");

  // an incomplete address byte never leads to an execute pulse
  property p_exec_needs_address;
    @(posedge clk) disable iff (rst)
      (sel_rise && !st_r.addr_done) |=> !cmd_valid;
  endproperty
  a_exec_needs_address: assert property (p_exec_needs_address)
    else $error("command executed without a complete address byte");
endmodule

// file: verification/host_model.sv
// host side model driving select, serial clock and command data pins
// assumes clk is the 100 MHz system clock; pins change on its falling edge
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire logic reply_data_out,
  input wire logic reply_data_oe,
  output logic select_n,
  output logic serial_clk,
  output logic command_data_in
);
  localparam int HALF = 12; // 120 ns half period, above the 100 ns minimum
  localparam int GAP = 110; // select high time between transfers
  logic tog = 1'b0;
  logic rd;
  ////////////////////////////////////////////////////////////////////////////////
  // an undriven reply wire shows a changing pattern, never the last driven bit
  always @(posedge clk) tog <= ~tog;
  assign rd = reply_data_oe ? reply_data_out : tog;
  initial begin
    select_n = 1'b1;
    serial_clk = 1'b0;
    command_data_in = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one transfer of nb stream bits msb first; reply bits 8..23 land in rx
  task automatic xfer(input logic cpol, input logic [31:0] s, input int nb,
                      output logic [15:0] rx);
    rx = 16'h0000;
    serial_clk = cpol; // either idle level
    wt(2);
    select_n = 1'b0;
    wt(HALF);
    for (int i = 0; i < nb; i++) begin
      serial_clk = 1'b0;
      command_data_in = s[31 - i]; // msb first, address byte leads
      wt(HALF);
      serial_clk = 1'b1;
      if (i >= 8 && i < 24) rx = {rx[14:0], rd};
      wt(HALF);
    end
    serial_clk = cpol;
    wt(HALF);
    select_n = 1'b1;
    command_data_in = ~command_data_in; // released line drops its last value
    wt(GAP); // select stays high 1.1 us
  endtask
endmodule

// file: verification/host_serial_command_port_test.sv
// self-checking bench of the serial command port with a host model
// assumes the design package and host_model are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module host_serial_command_port_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reply_en = 1'b0;
  logic [7:0] reply_data = 8'h00;
  logic select_n, serial_clk, command_data_in, reply_data_out, reply_data_oe;
  logic reply_load, addr_valid, cmd_valid;
  logic [7:0] cmd_addr, a_cap;
  logic [15:0] cmd_data, d_cap;
  logic [1:0] cmd_len, l_cap;
  int bad_count = 0;
  int cmp_count = 0;
  int cv_cnt, cv_early, av_cnt, rl_cnt, oe_cnt;
  int b_cv, b_early, b_av, b_rl, b_oe;
  ////////////////////////////////////////////////////////////////////////////////
  host_model i_host (.clk(clk), .reply_data_out(reply_data_out),
    .reply_data_oe(reply_data_oe), .select_n(select_n), .serial_clk(serial_clk),
    .command_data_in(command_data_in));
  host_serial_command_port i_dut (.clk(clk), .rst(rst), .select_n(select_n),
    .serial_clk(serial_clk), .command_data_in(command_data_in),
    .reply_data_out(reply_data_out), .reply_data_oe(reply_data_oe),
    .reply_en(reply_en), .reply_data(reply_data), .reply_load(reply_load),
    .addr_valid(addr_valid), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_len(cmd_len));
  initial begin
    forever #5 clk = ~clk;
  end
  // pulse counters and capture of the finished command; counts only grow,
  // so one driver each, and a transfer is judged against a snapshot
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) begin
      cv_cnt <= cv_cnt + 1;
      a_cap <= cmd_addr;
      d_cap <= cmd_data;
      l_cap <= cmd_len;
      if (select_n !== 1'b1) cv_early <= cv_early + 1;
    end
    if (addr_valid === 1'b1) av_cnt <= av_cnt + 1;
    if (reply_load === 1'b1) rl_cnt <= rl_cnt + 1;
    if (reply_data_oe === 1'b1) oe_cnt <= oe_cnt + 1;
  end
  function automatic int pick(input int k);
    case (k % 6)
      0: return 16;
      1: return 32;
      2: return 5;
      3: return 20;
      4: return 8;
      default: return 24;
    endcase
  endfunction
  // whole data bytes after the address, third and later ones dropped
  function automatic int dlen(input int nb);
    if (nb < 16) return 0;
    return ((nb - 8) / 8 > 2) ? 2 : (nb - 8) / 8;
  endfunction
  function automatic logic [15:0] dval(input logic [31:0] s, input int nb);
    if (dlen(nb) == 2) return s[23:8];
    if (dlen(nb) == 1) return {8'h00, s[23:16]};
    return 16'h0000;
  endfunction
  // reply byte loads: one per byte start after the address, plus the closing
  // fall of an idle-low clock when the stream ends on a byte boundary
  function automatic int nloads(input int nb, input logic cp);
    int n;
    n = 0;
    for (int j = 8; j < nb; j += 8) n++;
    if (!cp && nb >= 8 && nb % 8 == 0) n++;
    return n;
  endfunction
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // hand-picked cases first, then random ones
  initial begin
    logic [15:0] rx;
    logic [31:0] s;
    logic cp;
    int nb;
    void'($urandom(31636));
    repeat (6) @(negedge clk);
    rst = 1'b0;
    `CHK({cmd_addr, cmd_data, cmd_len, reply_data_oe, cmd_valid}, 28'h0000000)
    repeat (4) @(negedge clk);
    for (int k = 0; k < 14; k++) begin
      s = $urandom();
      cp = (k < 6) ? 1'(k % 2) : 1'($urandom_range(1));
      nb = (k < 6) ? pick(k) : pick($urandom_range(5));
      reply_data = 8'($urandom());
      reply_en = (k < 6) ? 1'b1 : 1'($urandom_range(1));
      b_cv = cv_cnt;
      b_early = cv_early;
      b_av = av_cnt;
      b_rl = rl_cnt;
      b_oe = oe_cnt;
      i_host.xfer(cp, s, nb, rx);
      `CHK(av_cnt - b_av, int'(nb >= 8))
      `CHK(cv_cnt - b_cv, int'(nb >= 8))
      `CHK(cv_early - b_early, 0)
      `CHK(rl_cnt - b_rl, nloads(nb, cp))
      `CHK(reply_data_oe, 1'b0)
      if (nb >= 8) begin
        `CHK(a_cap, s[31:24])
        `CHK(l_cap, 2'(dlen(nb)))
        `CHK(d_cap, dval(s, nb))
      end
      `CHK(1'(oe_cnt != b_oe), 1'(reply_en && nloads(nb, cp) > 0))
      if (reply_en && nb >= 24) `CHK(rx, {reply_data, reply_data})
    end
    conclude();
  end
endmodule
